// ---- verilog/cwt_cfg.svh ----
// Constants for the calibration waveform timing block
// Contract
// R1: Master select gives 32768 Hz, 32000 Hz for codes 01/10, 31968 Hz.
// R2: Heart sample rate follows master select and rate field; 10/11 allow rate 10.
// R3: Bioimpedance rate from one rate bit and master select.
// R4: Pacer time step 15.26, 15.63 or 15.64 us by master select.
// R5: Pace record depth 128/256/512 by rate code, 320 for masters 10/11.
// R6: Calibration time step 30.52, 31.25 or 31.28 us by master select.
// R7: Wave period is master frequency divided by 2^7 up to 2^21.
// R8: Half-duty bit set gives 50% high time, high-time field ignored.
// R9: Half-duty clear gives high time of field times calibration step.
// R10: Unipolar swings mid to mid plus/minus amplitude; bipolar plus to minus.
// R11: Amplitude bit selects 0.25 mV or 0.50 mV.
// R12: Source enable clear disables sources and all calibration modes.
// R13: Reset: frequency 100, half-duty 1, high time 0, other bits 0.
// R14: Calibration configuration register is readable and writable.
// R15: Calibration outputs can be routed to the channel inputs.
// R16: Software should open input switches before applying a source.
// R17: Input mux register holds invert, two open bits, two selects.
// R18: Select 00 none, 01 midpoint, 10 positive, 11 negative source.
// R19: Input-open bits reset to 1, isolating; writing 0 connects.
// R20: Master frequency derives from the 32.768 kHz reference clock.
// R21: Free-running period counter at master rate compared to threshold.
// R22: Source enable clear forces midpoint and clears the period counter.
`ifndef CWT_CFG_SVH
`define CWT_CFG_SVH
`define CWT_ADDR_CAL 8'h12
`define CWT_ADDR_EMUX 8'h14
`define CWT_ADDR_TIMING 8'h20
`define CWT_ADDR_STATUS 8'h21
`define CWT_CAL_RESET 24'h004800
`define CWT_EMUX_RESET 24'h300000
`define CWT_TIMING_RESET 24'h800000
`define CWT_CAL_ON_BIT 22
`define CWT_CAL_POL_BIT 21
`define CWT_CAL_AMP_BIT 20
`define CWT_CAL_FREQ_RNG 14:12
`define CWT_CAL_HALF_BIT 11
`define CWT_CAL_HIGH_RNG 10:0
`define CWT_CAL_MASK 24'h707FFF
`define CWT_EMUX_INV_BIT 23
`define CWT_EMUX_OPENP_BIT 21
`define CWT_EMUX_OPENN_BIT 20
`define CWT_EMUX_CALP_RNG 19:18
`define CWT_EMUX_CALN_RNG 17:16
`define CWT_EMUX_MASK 24'hBF0000
`define CWT_TIM_HRATE_RNG 23:22
`define CWT_TIM_MASTER_RNG 21:20
`define CWT_TIM_BRATE_BIT 19
`define CWT_TIM_MASK 24'hF80000
`define CWT_REF_HZ 17'h08000
`define CWT_FM_HZ_00 17'h08000
`define CWT_FM_HZ_01 17'h07D00
`define CWT_FM_HZ_11 17'h07CE0
`define CWT_HR_512 16'hC800
`define CWT_HR_256 16'h6400
`define CWT_HR_128 16'h3200
`define CWT_HR_500 16'hC350
`define CWT_HR_250 16'h61A8
`define CWT_HR_125 16'h30D4
`define CWT_HR_200 16'h4E20
`define CWT_HR_1998 16'h4E0C
`define CWT_BR_64 16'h1900
`define CWT_BR_32 16'h0C80
`define CWT_BR_6250 16'h186A
`define CWT_BR_3125 16'h0C35
`define CWT_BR_50 16'h1388
`define CWT_BR_25 16'h09C4
`define CWT_BR_4995 16'h1383
`define CWT_BR_2498 16'h09C2
`define CWT_PACE_NS_00 16'h3B9C
`define CWT_PACE_NS_01 16'h3D0E
`define CWT_PACE_NS_11 16'h3D18
`define CWT_CAL_NS_00 16'h7738
`define CWT_CAL_NS_01 16'h7A12
`define CWT_CAL_NS_11 16'h7A30
`define CWT_DEPTH_128 10'h080
`define CWT_DEPTH_256 10'h100
`define CWT_DEPTH_512 10'h200
`define CWT_DEPTH_320 10'h140
`define CWT_PERIOD_FULL 22'h3FFFFF
`define CWT_PERIOD_SHIFT0 4'hF
`endif

// ---- verilog/cwt_pkg.sv ----
// Types for the calibration waveform timing block
package cwt_pkg;
	typedef enum logic [1:0] {LVL_MID, LVL_PLUS, LVL_MINUS} cwt_level_t;
	typedef enum logic [1:0] {
		ROUTE_NONE,
		ROUTE_MID,
		ROUTE_CAL_POS,
		ROUTE_CAL_NEG
	} cwt_route_t;
	typedef struct packed {
		logic invert;
		logic pos_open;
		logic neg_open;
		cwt_route_t pos_route;
		cwt_route_t neg_route;
	} cwt_mux_t;
	typedef struct packed {
		logic [15:0] heart_rate_csps;
		logic [15:0] bioimp_rate_csps;
		logic [15:0] pacer_step_ns;
		logic [15:0] cal_step_ns;
		logic [9:0] pace_depth;
		logic rate_invalid;
	} cwt_timing_t;
endpackage : cwt_pkg

// ---- verilog/cwt_top.sv ----
// Calibration waveform generator, timing tables and input mux configuration
`timescale 1ns/1ns
`default_nettype none
`include "cwt_cfg.svh"
module cwt_top (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic slow_ref_clock,
	input wire logic [7:0] bus_addr,
	input wire logic [23:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [23:0] bus_rdata,
	output logic master_tick,
	output cwt_pkg::cwt_level_t cal_out_pos,
	output cwt_pkg::cwt_level_t cal_out_neg,
	output logic cal_amplitude_sel,
	output cwt_pkg::cwt_mux_t mux_out,
	output cwt_pkg::cwt_timing_t timing_out
);
	import cwt_pkg::*;

	logic [23:0] cal_reg;
	logic [23:0] emux_reg;
	logic [23:0] timing_reg;
	logic ref_s1_reg;
	logic ref_s2_reg;
	logic ref_s3_reg;
	logic ref_level_reg;
	logic [16:0] acc_reg;
	logic [16:0] acc_next;
	logic tick_reg;
	logic [21:0] cnt_reg;
	logic [21:0] cnt_next;
	logic [23:0] rdata_reg;
	logic [23:0] rdata_next;
	cwt_level_t pos_reg;
	cwt_level_t neg_reg;
	cwt_level_t pos_next;
	cwt_level_t neg_next;
	logic amp_reg;
	cwt_mux_t mux_reg;
	cwt_mux_t mux_next;
	cwt_timing_t tim_reg;
	cwt_timing_t tim_next;

	// Register fields
	wire cal_source_on = cal_reg[`CWT_CAL_ON_BIT];
	wire cal_polarity_mode = cal_reg[`CWT_CAL_POL_BIT];
	wire cal_amp_bit = cal_reg[`CWT_CAL_AMP_BIT];
	wire [2:0] cal_freq_sel = cal_reg[`CWT_CAL_FREQ_RNG];
	wire cal_half_duty = cal_reg[`CWT_CAL_HALF_BIT];
	wire [10:0] cal_high_time = cal_reg[`CWT_CAL_HIGH_RNG];
	wire heart_input_invert = emux_reg[`CWT_EMUX_INV_BIT];
	wire pos_input_open = emux_reg[`CWT_EMUX_OPENP_BIT];
	wire neg_input_open = emux_reg[`CWT_EMUX_OPENN_BIT];
	wire [1:0] pos_input_cal_sel = emux_reg[`CWT_EMUX_CALP_RNG];
	wire [1:0] neg_input_cal_sel = emux_reg[`CWT_EMUX_CALN_RNG];
	wire [1:0] master_freq_select = timing_reg[`CWT_TIM_MASTER_RNG];
	wire [1:0] heart_rate_sel = timing_reg[`CWT_TIM_HRATE_RNG];
	wire bioimp_rate_sel = timing_reg[`CWT_TIM_BRATE_BIT];

	// Bus decode
	wire sel_cal = bus_addr == `CWT_ADDR_CAL;
	wire sel_emux = bus_addr == `CWT_ADDR_EMUX;
	wire sel_tim = bus_addr == `CWT_ADDR_TIMING;
	wire sel_stat = bus_addr == `CWT_ADDR_STATUS;
	wire wr_cal = bus_wr && sel_cal;
	wire wr_emux = bus_wr && sel_emux;
	wire wr_tim = bus_wr && sel_tim;
	wire [23:0] status_word = {tim_reg.rate_invalid, tick_reg,
		pos_reg, neg_reg, 2'h0, tim_reg.heart_rate_csps};

	always_comb begin
		rdata_next = 24'h000000;
		if (bus_rd) begin
			if (sel_cal)
				rdata_next = cal_reg; // [R14]
			else if (sel_emux)
				rdata_next = emux_reg; // [R17]
			else if (sel_tim)
				rdata_next = timing_reg;
			else if (sel_stat)
				rdata_next = status_word;
		end
	end

	// Configuration registers: masked write data, held otherwise
	wire [23:0] cal_next = wr_cal ?
		(bus_wdata & `CWT_CAL_MASK) : cal_reg; // [R14]
	wire [23:0] emux_next = wr_emux ?
		(bus_wdata & `CWT_EMUX_MASK) : emux_reg; // [R17]
	wire [23:0] timing_next = wr_tim ?
		(bus_wdata & `CWT_TIM_MASK) : timing_reg;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			cal_reg <= `CWT_CAL_RESET; // [R13]
		else
			cal_reg <= cal_next;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			emux_reg <= `CWT_EMUX_RESET; // [R19]
		else
			emux_reg <= emux_next;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			timing_reg <= `CWT_TIMING_RESET;
		else
			timing_reg <= timing_next;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			rdata_reg <= 24'h000000;
		else
			rdata_reg <= rdata_next;
	end

	// Reference clock pin: three stages, change taken when stages 2 and 3 agree
	wire ref_agree = ref_s2_reg == ref_s3_reg;
	wire ref_rise = ref_agree && ref_s3_reg && !ref_level_reg;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ref_s1_reg <= 1'b0;
			ref_s2_reg <= 1'b0;
			ref_s3_reg <= 1'b0;
		end else begin
			ref_s1_reg <= slow_ref_clock;
			ref_s2_reg <= ref_s1_reg;
			ref_s3_reg <= ref_s2_reg;
		end
	end

	// Settled pin level, moved only when stages 2 and 3 agree
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			ref_level_reg <= 1'b0;
		else if (ref_agree)
			ref_level_reg <= ref_s3_reg;
	end

	// Master frequency: fractional rate from the 32768 Hz reference
	wire [16:0] fm_inc = (master_freq_select == 2'h0) ? `CWT_FM_HZ_00 :
		(master_freq_select == 2'h3) ? `CWT_FM_HZ_11 :
		`CWT_FM_HZ_01; // [R1]
	wire [16:0] acc_sum = acc_reg + fm_inc; // [R20]
	wire acc_wrap = acc_sum >= `CWT_REF_HZ;

	always_comb begin
		acc_next = acc_reg;
		if (ref_rise) begin
			if (acc_wrap)
				acc_next = acc_sum - `CWT_REF_HZ;
			else
				acc_next = acc_sum;
		end
	end

	wire tick_next = ref_rise && acc_wrap; // [R20]

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			acc_reg <= 17'h00000;
		else
			acc_reg <= acc_next;
	end

	// Tick pulse: one mclk cycle per master period
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			tick_reg <= 1'b0;
		else
			tick_reg <= tick_next;
	end

	// Period counter and high threshold
	wire [3:0] shift_amt = `CWT_PERIOD_SHIFT0 - {cal_freq_sel, 1'b0};
	wire [21:0] period_last = `CWT_PERIOD_FULL >> shift_amt; // [R7]
	wire [21:0] half_last = period_last >> 1;
	// One calibration step is one master period, so high time counts ticks
	wire [21:0] high_ticks = {11'h000, cal_high_time}; // [R6]
	wire half_high = cnt_reg <= half_last; // [R8]
	wire field_high = cnt_reg < high_ticks; // [R9]
	wire wave_high = cal_half_duty ? half_high : field_high;
	wire period_end = cnt_reg >= period_last; // [R7]

	always_comb begin
		cnt_next = cnt_reg;
		if (!cal_source_on)
			cnt_next = 22'h000000; // [R22]
		else if (tick_reg) begin
			if (period_end)
				cnt_next = 22'h000000; // [R7]
			else
				cnt_next = cnt_reg + 22'h000001; // [R21]
		end
	end

	// Source levels
	always_comb begin
		pos_next = LVL_MID;
		neg_next = LVL_MID;
		if (cal_source_on) begin // [R12]
			if (cal_polarity_mode) begin
				pos_next = wave_high ? LVL_PLUS : LVL_MINUS; // [R10]
				neg_next = wave_high ? LVL_MINUS : LVL_PLUS;
			end else begin
				pos_next = wave_high ? LVL_PLUS : LVL_MID; // [R10]
				neg_next = wave_high ? LVL_MINUS : LVL_MID;
			end
		end
	end

	// Reset and disable both park the counter at zero
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			cnt_reg <= 22'h000000;
		else
			cnt_reg <= cnt_next;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pos_reg <= LVL_MID;
			neg_reg <= LVL_MID;
		end else begin
			pos_reg <= pos_next;
			neg_reg <= neg_next;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			amp_reg <= 1'b0;
		else
			amp_reg <= cal_amp_bit; // [R11]
	end

	// Input mux routing
	function automatic cwt_route_t route_of(input logic [1:0] sel,
		input logic on);
		route_of = ROUTE_NONE;
		case (sel)
			2'h1: route_of = ROUTE_MID;
			2'h2: route_of = on ? ROUTE_CAL_POS : ROUTE_NONE;
			2'h3: route_of = on ? ROUTE_CAL_NEG : ROUTE_NONE;
			default: route_of = ROUTE_NONE;
		endcase
	endfunction : route_of

	always_comb begin
		mux_next.invert = heart_input_invert;
		mux_next.pos_open = pos_input_open; // [R19]
		mux_next.neg_open = neg_input_open; // [R19]
		mux_next.pos_route = route_of(pos_input_cal_sel,
			cal_source_on); // [R18] [R15]
		mux_next.neg_route = route_of(neg_input_cal_sel,
			cal_source_on); // [R18] [R15]
	end

	// Derived timing figures
	always_comb begin
		tim_next.rate_invalid = 1'b0;
		tim_next.heart_rate_csps = 16'h0000;
		tim_next.pace_depth = `CWT_DEPTH_320;
		unique case (master_freq_select)
			2'h0: begin
				tim_next.pacer_step_ns = `CWT_PACE_NS_00; // [R4]
				tim_next.cal_step_ns = `CWT_CAL_NS_00; // [R6]
				tim_next.bioimp_rate_csps = bioimp_rate_sel ?
					`CWT_BR_32 : `CWT_BR_64; // [R3]
			end
			2'h1: begin
				tim_next.pacer_step_ns = `CWT_PACE_NS_01;
				tim_next.cal_step_ns = `CWT_CAL_NS_01;
				tim_next.bioimp_rate_csps = bioimp_rate_sel ?
					`CWT_BR_3125 : `CWT_BR_6250;
			end
			2'h2: begin
				tim_next.pacer_step_ns = `CWT_PACE_NS_01;
				tim_next.cal_step_ns = `CWT_CAL_NS_01;
				tim_next.bioimp_rate_csps = bioimp_rate_sel ?
					`CWT_BR_25 : `CWT_BR_50;
			end
			2'h3: begin
				tim_next.pacer_step_ns = `CWT_PACE_NS_11;
				tim_next.cal_step_ns = `CWT_CAL_NS_11;
				tim_next.bioimp_rate_csps = bioimp_rate_sel ?
					`CWT_BR_2498 : `CWT_BR_4995;
			end
		endcase
		if (!master_freq_select[1]) begin
			unique case (heart_rate_sel)
				2'h0: begin
					tim_next.heart_rate_csps = master_freq_select[0] ?
						`CWT_HR_500 : `CWT_HR_512; // [R2]
					tim_next.pace_depth = `CWT_DEPTH_128; // [R5]
				end
				2'h1: begin
					tim_next.heart_rate_csps = master_freq_select[0] ?
						`CWT_HR_250 : `CWT_HR_256;
					tim_next.pace_depth = `CWT_DEPTH_256;
				end
				2'h2: begin
					tim_next.heart_rate_csps = master_freq_select[0] ?
						`CWT_HR_125 : `CWT_HR_128;
					tim_next.pace_depth = `CWT_DEPTH_512;
				end
				2'h3: begin
					tim_next.rate_invalid = 1'b1;
					tim_next.pace_depth = `CWT_DEPTH_512;
				end
			endcase
		end else if (heart_rate_sel == 2'h2) begin
			tim_next.heart_rate_csps = master_freq_select[0] ?
				`CWT_HR_1998 : `CWT_HR_200; // [R2]
		end else begin
			tim_next.rate_invalid = 1'b1; // [R2]
		end
	end

	// Routing and timing tables, refreshed every cycle
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			mux_reg <= '{1'b0, 1'b1, 1'b1, ROUTE_NONE, ROUTE_NONE};
		else
			mux_reg <= mux_next;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			tim_reg <= '0;
		else
			tim_reg <= tim_next;
	end

	assign bus_rdata = rdata_reg;
	assign master_tick = tick_reg;
	assign cal_out_pos = pos_reg;
	assign cal_out_neg = neg_reg;
	assign cal_amplitude_sel = amp_reg;
	assign mux_out = mux_reg;
	assign timing_out = tim_reg;
endmodule : cwt_top
`default_nettype wire

// ---- dv/cwt_props.sv ----
// Property checker for the calibration waveform timing block
`timescale 1ns/1ns
`default_nettype none
module cwt_props (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic slow_ref_clock,
	input wire logic [7:0] bus_addr,
	input wire logic [23:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [23:0] bus_rdata,
	input wire logic master_tick,
	input wire cwt_pkg::cwt_level_t cal_out_pos,
	input wire cwt_pkg::cwt_level_t cal_out_neg,
	input wire logic cal_amplitude_sel,
	input wire cwt_pkg::cwt_mux_t mux_out,
	input wire cwt_pkg::cwt_timing_t timing_out
);
	import cwt_pkg::*;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	function automatic logic [15:0] cal_ns(logic [1:0] m);
		return m == 2'h0 ? 16'h7738 : (m == 2'h3 ? 16'h7A30 : 16'h7A12);
	endfunction : cal_ns
	function automatic logic [15:0] pace_ns(logic [1:0] m);
		return m == 2'h0 ? 16'h3B9C : (m == 2'h3 ? 16'h3D18 : 16'h3D0E);
	endfunction : pace_ns
	sequence s_wr(a);
		bus_wr && bus_addr == a;
	endsequence
	property p_amp;
		logic v;
		(s_wr(8'h12), v = bus_wdata[20]) |-> ##2 cal_amplitude_sel == v;
	endproperty
	property p_open;
		logic v;
		(s_wr(8'h14), v = bus_wdata[21]) |-> ##2 mux_out.pos_open == v;
	endproperty
	property p_cal;
		logic [1:0] m;
		(s_wr(8'h20), m = bus_wdata[21:20])
			|-> ##2 timing_out.cal_step_ns == cal_ns(m);
	endproperty
	property p_pace;
		logic [1:0] m;
		(s_wr(8'h20), m = bus_wdata[21:20])
			|-> ##2 timing_out.pacer_step_ns == pace_ns(m);
	endproperty
	a_rdata_idle: assert property (!bus_rd |=> bus_rdata == 24'h000000)
		else $error("read data not idle");
	a_unmapped_read: assert property (bus_rd && !(bus_addr inside
		{8'h12, 8'h14, 8'h20, 8'h21}) |=> bus_rdata == 24'h000000)
		else $error("unmapped read not zero");
	a_tick_pulse: assert property (master_tick |=> !master_tick)
		else $error("master tick longer than one cycle");
	a_mid_pair: assert property (cal_out_pos == LVL_MID |->
		cal_out_neg == LVL_MID) else $error("sources not both at midpoint");
	a_plus_pair: assert property (cal_out_pos == LVL_PLUS |->
		cal_out_neg == LVL_MINUS) else $error("negative source wrong level");
	a_minus_pair: assert property (cal_out_pos == LVL_MINUS |->
		cal_out_neg == LVL_PLUS) else $error("bipolar pair wrong level");
	a_amp_follow: assert property (p_amp)
		else $error("amplitude select not updated");
	a_open_follow: assert property (p_open)
		else $error("positive open bit not updated");
	a_cal_step: assert property (p_cal) else $error("cal step wrong");
	a_pace_step: assert property (p_pace) else $error("pace step wrong");
endmodule : cwt_props
bind cwt_top cwt_props u_props (.mclk(mclk), .rstn(rstn),
	.slow_ref_clock(slow_ref_clock), .bus_addr(bus_addr),
	.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
	.bus_rdata(bus_rdata), .master_tick(master_tick),
	.cal_out_pos(cal_out_pos), .cal_out_neg(cal_out_neg),
	.cal_amplitude_sel(cal_amplitude_sel), .mux_out(mux_out),
	.timing_out(timing_out));
`default_nettype wire

// ---- dv/test_calibration_waveform_timing.sv ----
// Self-checking bench for the calibration waveform timing block
`timescale 1ns/1ns
`default_nettype none
module test_calibration_waveform_timing;
	import cwt_pkg::*;
	logic mclk = 1'h0;
	logic rstn = 1'h0;
	logic slow_ref_clock = 1'h0;
	logic bus_wr = 1'h0;
	logic bus_rd = 1'h0;
	logic [7:0] bus_addr = 8'h00;
	logic [23:0] bus_wdata = 24'h000000;
	logic [23:0] bus_rdata;
	logic [23:0] d;
	logic master_tick;
	logic cal_amplitude_sel;
	cwt_level_t cal_out_pos;
	cwt_level_t cal_out_neg;
	cwt_mux_t mux_out;
	cwt_timing_t timing_out;
	int bad_count = 0;
	int n_checks = 0;
	int n;
	logic [23:0] tw [7] = '{24'h800000, 24'h900000, 24'hA00000, 24'hB80000,
		24'h080000, 24'h580000, 24'h280000};
	logic [74:0] te [7] = '{
		{16'h3200, 16'h1900, 16'h3B9C, 16'h7738, 10'h200, 1'h0},
		{16'h30D4, 16'h186A, 16'h3D0E, 16'h7A12, 10'h200, 1'h0},
		{16'h4E20, 16'h1388, 16'h3D0E, 16'h7A12, 10'h140, 1'h0},
		{16'h4E0C, 16'h09C2, 16'h3D18, 16'h7A30, 10'h140, 1'h0},
		{16'hC800, 16'h0C80, 16'h3B9C, 16'h7738, 10'h080, 1'h0},
		{16'h61A8, 16'h0C35, 16'h3D0E, 16'h7A12, 10'h100, 1'h0},
		{16'h0000, 16'h09C4, 16'h3D0E, 16'h7A12, 10'h140, 1'h1}};
	always #50 mclk = ~mclk;
	always #15259 slow_ref_clock = ~slow_ref_clock;
	cwt_top dut (.mclk(mclk), .rstn(rstn), .slow_ref_clock(slow_ref_clock),
		.bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
		.bus_rd(bus_rd), .bus_rdata(bus_rdata), .master_tick(master_tick),
		.cal_out_pos(cal_out_pos), .cal_out_neg(cal_out_neg),
		.cal_amplitude_sel(cal_amplitude_sel), .mux_out(mux_out),
		.timing_out(timing_out));
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : close_out
	task automatic chk(input string nm, input logic [74:0] e, input logic [74:0] g);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [23:0] v);
		@(posedge mclk);
		bus_wr <= 1'h1;
		bus_addr <= a;
		bus_wdata <= v;
		@(posedge mclk);
		bus_wr <= 1'h0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge mclk);
		bus_rd <= 1'h1;
		bus_addr <= a;
		@(posedge mclk);
		bus_rd <= 1'h0;
		#1 d = bus_rdata;
	endtask : rd
	task automatic settle();
		repeat (3) @(posedge mclk);
		#1;
	endtask : settle
	// Counts master ticks until the positive source reaches a level
	task automatic run_until(input cwt_level_t v, output int t);
		t = 0;
		for (int i = 0; i < 50000 && cal_out_pos !== v; i++) begin
			@(posedge mclk);
			#1;
			if (master_tick === 1'h1) t++;
		end
		if (cal_out_pos !== v) begin
			bad_count++;
			close_out();
		end
	endtask : run_until
	initial begin
		#9000000;
		bad_count++;
		close_out();
	end
	initial begin
		repeat (3) @(posedge mclk);
		rstn <= 1'h1;
		rd(8'h12);
		chk("cal reset", 24'h004800, d);
		rd(8'h14);
		chk("mux reset", 24'h300000, d);
		wr(8'h12, 24'hFFFFFF);
		rd(8'h12);
		chk("cal rw", 24'h707FFF, d);
		wr(8'h12, 24'h004800);
		wr(8'h14, 24'hFFFFFF);
		rd(8'h14);
		chk("mux rw", 24'hBF0000, d);
		chk("mux off", {3'h7, ROUTE_NONE, ROUTE_NONE}, mux_out);
		wr(8'h14, 24'h340000);
		settle();
		chk("mux mid", {3'h3, ROUTE_MID, ROUTE_NONE}, mux_out);
		wr(8'h33, 24'hFFFFFF);
		rd(8'h33);
		chk("unmapped", 24'h000000, d);
		$display("register test done");
		for (int i = 0; i < 7; i++) begin
			wr(8'h20, tw[i]);
			settle();
			chk("timing", te[i], timing_out);
		end
		$display("timing test done");
		wr(8'h20, 24'h800000);
		wr(8'h14, 24'hBE0000);
		wr(8'h12, 24'h500005);
		run_until(LVL_PLUS, n);
		chk("neg level", LVL_MINUS, cal_out_neg);
		chk("amplitude", 1'h1, cal_amplitude_sel);
		chk("mux on", {3'h7, ROUTE_CAL_NEG, ROUTE_CAL_POS}, mux_out);
		run_until(LVL_MID, n);
		chk("high ticks", 8'h05, n);
		run_until(LVL_PLUS, n);
		chk("low ticks", 8'h7B, n);
		$display("high time test done");
		wr(8'h12, 24'h000000);
		settle();
		chk("off level", LVL_MID, cal_out_pos);
		chk("mux gated", {3'h7, ROUTE_NONE, ROUTE_NONE}, mux_out);
		wr(8'h12, 24'h600800);
		run_until(LVL_PLUS, n);
		run_until(LVL_MINUS, n);
		chk("half ticks", 8'h40, n);
		chk("bipolar neg", LVL_PLUS, cal_out_neg);
		$display("half duty test done");
		close_out();
	end
endmodule : test_calibration_waveform_timing
`default_nettype wire
